// >>> logic/charger_regs_pkg.sv
package charger_regs_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned WD_SHORT_S = 10;
  localparam int unsigned WD_MID_S = 60;
  localparam int unsigned WD_LONG_S = 180;
  localparam int unsigned TERM_HOLD_S = 5;
  localparam int unsigned BLEED_MS = 100;
  localparam int unsigned CHG_TMO_SHORT_HR = 12;
  localparam int unsigned CHG_TMO_MID_HR = 24;
  localparam int unsigned CHG_TMO_LONG_HR = 48;
  localparam int unsigned WD_SHORT_TICKS = WD_SHORT_S * 1000 / TICK_MS;
  localparam int unsigned WD_MID_TICKS = WD_MID_S * 1000 / TICK_MS;
  localparam int unsigned WD_LONG_TICKS = WD_LONG_S * 1000 / TICK_MS;
  localparam int unsigned TERM_TICKS = TERM_HOLD_S * 1000 / TICK_MS;
  localparam int unsigned BLEED_TICKS = BLEED_MS / TICK_MS;
  localparam int unsigned CHG_SHORT_TICKS = CHG_TMO_SHORT_HR * 3600 * 1000 / TICK_MS;
  localparam int unsigned CHG_MID_TICKS = CHG_TMO_MID_HR * 3600 * 1000 / TICK_MS;
  localparam int unsigned CHG_LONG_TICKS = CHG_TMO_LONG_HR * 3600 * 1000 / TICK_MS;
  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h0B;
  localparam logic [7:0] OFS_CHG = 8'h0C;
  localparam logic [7:0] OFS_PROT = 8'h0D;
  localparam logic [7:0] OFS_TGA = 8'h0E;
  localparam logic [7:0] OFS_NTC = 8'h0F;
  localparam logic [7:0] OFS_MEAS = 8'h10;
  localparam logic [7:0] RST_MODE = 8'h20;
  localparam logic [7:0] RST_CHG = 8'h19;
  localparam logic [7:0] RST_PROT = 8'h60;
  localparam logic [7:0] RST_TGA = 8'h31;
  localparam logic [7:0] RST_NTC = 8'h55;
  localparam logic [7:0] RST_MEAS = 8'h7C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned B_MODE_SRC = 7;
  localparam int unsigned B_SPREAD = 1;
  localparam int unsigned B_TARGET = 7;
  localparam int unsigned B_BASIS = 6;
  localparam int unsigned B_PRETH = 5;
  localparam int unsigned B_PREEN = 4;
  localparam int unsigned B_AUTOTERM = 0;
  localparam int unsigned B_SRCFB = 7;
  localparam int unsigned B_KICK = 4;
  localparam int unsigned B_OCP = 3;
  localparam int unsigned B_UVSEL = 2;
  localparam int unsigned B_ILIM = 1;
  localparam int unsigned B_LS1 = 5;
  localparam int unsigned B_LS2 = 4;
  localparam int unsigned B_BLEED = 3;
  localparam int unsigned B_REGRST = 2;
  localparam int unsigned B_TRESTART = 1;
  localparam int unsigned B_ADSTART = 7;
  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [1:0] WD_OFF = 2'h3;
  localparam logic [1:0] CHG_TMO_OFF = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_CHARGE = 2'h1;
  localparam logic [1:0] MODE_SOURCE = 2'h2;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_REG = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
endpackage : charger_regs_pkg

// >>> logic/charger_control_register_bank.sv
`timescale 1ns/10ps
module charger_control_register_bank
  import charger_regs_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial link
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // converter status
  input wire logic converter_active,
  input wire logic batt_at_voltage,
  input wire logic charge_current_low,
  // mode and protection
  output logic [1:0] op_mode,
  output logic switch_halt,
  output logic charge_terminated,
  output logic bus_bleed_active,
  // configuration
  output logic freq_spread_enable,
  output logic batt_target_source_sel,
  output logic charge_current_basis_sel,
  output logic precharge_threshold_sel,
  output logic precharge_enable,
  output logic [2:0] termination_current_level,
  output logic source_out_target_sel,
  output logic source_out_overcurrent_enable,
  output logic batt_undervolt_threshold_sel,
  output logic inductor_current_limit_sel,
  output logic [1:0] active_hot_limit,
  output logic [1:0] active_cold_limit,
  output logic conversion_start,
  output logic bus_voltage_channel_enable,
  output logic bus_current_channel_enable,
  output logic batt_voltage_channel_enable,
  // load-switch pins
  output logic load_switch1_pin_o,
  output logic load_switch1_pin_oe,
  output logic gate2_spread_pin_o,
  output logic gate2_spread_pin_oe
);

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_RX = 3'b001,
    L_ACK = 3'b010,
    L_TX = 3'b011,
    L_RACK = 3'b100
  } link_state_e;

  // ----------------------------------------
  // link domain: pin sampling
  // ----------------------------------------
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------
  // link domain: serial slave
  // ----------------------------------------
  link_state_e lst_r;
  logic [7:0] sh_r, ptr_r, wr_addr_r, wr_data_r, rd_addr_r, rd_word_r, rd_data_r;
  logic [3:0] bcnt_r;
  logic [1:0] kind_r;
  logic rd_mode_r, wr_tgl_r, rd_tgl_r, rd_ack_tgl_r, sda_oe_r, sda_o_r;
  logic ack_m_r, ack_s_r, ack_d_r;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      ack_d_r <= 1'b0;
      rd_word_r <= 8'h00;
      sda_o_r <= 1'b0;
    end else begin
      ack_m_r <= rd_ack_tgl_r;
      ack_s_r <= ack_m_r;
      ack_d_r <= ack_s_r;
      sda_o_r <= 1'b0;
      if (ack_s_r ^ ack_d_r) begin
        rd_word_r <= rd_data_r;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_r <= L_IDLE;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      bcnt_r <= 4'h0;
      kind_r <= KIND_ADDR;
      rd_mode_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_tgl_r <= 1'b0;
      rd_addr_r <= 8'h00;
      rd_tgl_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      lst_r <= L_RX;
      bcnt_r <= 4'h0;
      kind_r <= KIND_ADDR;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      lst_r <= L_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (lst_r)
        L_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            bcnt_r <= bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == 4'h8) begin
            bcnt_r <= 4'h0;
            sda_oe_r <= 1'b1;
            lst_r <= L_ACK;
            case (kind_r)
              KIND_ADDR: begin
                rd_mode_r <= sh_r[0];
                kind_r <= KIND_REG;
                if (sh_r[7:1] != DEV_ADDR) begin
                  sda_oe_r <= 1'b0;
                  lst_r <= L_IDLE;
                end else if (sh_r[0]) begin
                  rd_addr_r <= ptr_r;
                  rd_tgl_r <= ~rd_tgl_r;
                end
              end
              KIND_REG: begin
                ptr_r <= sh_r;
                kind_r <= KIND_DATA;
              end
              default: begin
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                wr_tgl_r <= ~wr_tgl_r;
                ptr_r <= ptr_r + 8'h01;
              end
            endcase
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            if (rd_mode_r) begin
              sh_r <= rd_word_r;
              sda_oe_r <= ~rd_word_r[7];
              bcnt_r <= 4'h1;
              lst_r <= L_TX;
            end else begin
              sda_oe_r <= 1'b0;
              lst_r <= L_RX;
            end
          end
        end
        L_TX: begin
          if (scl_fall) begin
            if (bcnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              lst_r <= L_RACK;
            end else begin
              sda_oe_r <= ~sh_r[6];
              sh_r <= {sh_r[6:0], 1'b0};
              bcnt_r <= bcnt_r + 4'h1;
            end
          end
        end
        L_RACK: begin
          if (scl_rise) begin
            if (!sda_s_r) begin
              ptr_r <= ptr_r + 8'h01;
              rd_addr_r <= ptr_r + 8'h01;
              rd_tgl_r <= ~rd_tgl_r;
              lst_r <= L_ACK;
            end else begin
              lst_r <= L_IDLE;
            end
          end
        end
        default: lst_r <= L_IDLE;
      endcase
    end
  end

  assign sda_oe = sda_oe_r;
  assign sda_o = sda_o_r;

  // ----------------------------------------
  // system domain: crossings
  // ----------------------------------------
  logic wr_m_r, wr_s_r, wr_d_r, rd_m_r, rd_s_r, rd_d_r, act_m_r, act_s_r;
  logic wr_fire;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_m_r <= 1'b0;
      wr_s_r <= 1'b0;
      wr_d_r <= 1'b0;
      rd_m_r <= 1'b0;
      rd_s_r <= 1'b0;
      rd_d_r <= 1'b0;
      act_m_r <= 1'b0;
      act_s_r <= 1'b0;
    end else if (clk_en) begin
      wr_m_r <= wr_tgl_r;
      wr_s_r <= wr_m_r;
      wr_d_r <= wr_s_r;
      rd_m_r <= rd_tgl_r;
      rd_s_r <= rd_m_r;
      rd_d_r <= rd_s_r;
      act_m_r <= converter_active;
      act_s_r <= act_m_r;
    end
  end

  assign wr_fire = wr_s_r ^ wr_d_r;

  // ----------------------------------------
  // system domain: registers
  // ----------------------------------------
  logic [7:0] mode_r, chg_r, prot_r, tga_r, ntc_r, meas_r, rd_mux;
  logic [1:0] op_mode_r;
  logic in_idle, kick, bleed_go, tmr_restart;

  assign in_idle = (op_mode_r == MODE_IDLE);
  assign kick = wr_fire && wr_addr_r == OFS_PROT && wr_data_r[B_KICK];
  assign bleed_go = wr_fire && wr_addr_r == OFS_TGA && wr_data_r[B_BLEED];
  assign tmr_restart = wr_fire && wr_addr_r == OFS_TGA && wr_data_r[B_TRESTART];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= RST_MODE;
      chg_r <= RST_CHG;
      prot_r <= RST_PROT;
      tga_r <= RST_TGA;
      ntc_r <= RST_NTC;
      meas_r <= RST_MEAS;
    end else if (clk_en && wr_fire) begin
      case (wr_addr_r)
        OFS_MODE: begin
          mode_r[3:0] <= wr_data_r[3:0];
          if (in_idle) begin
            mode_r[7:4] <= wr_data_r[7:4];
          end
        end
        OFS_CHG: begin
          chg_r[6:0] <= wr_data_r[6:0];
          if (in_idle) begin
            chg_r[B_TARGET] <= wr_data_r[B_TARGET];
          end
        end
        OFS_PROT: begin
          prot_r[6:0] <= {wr_data_r[6:5], 1'b0, wr_data_r[3:0]};
          if (in_idle) begin
            prot_r[B_SRCFB] <= wr_data_r[B_SRCFB];
          end
        end
        OFS_TGA: begin
          if (wr_data_r[B_REGRST] && in_idle) begin
            mode_r <= RST_MODE;
            chg_r <= RST_CHG;
            prot_r <= RST_PROT;
            tga_r <= RST_TGA;
            ntc_r <= RST_NTC;
            meas_r <= RST_MEAS;
          end else begin
            tga_r <= {wr_data_r[7:4], 3'b000, wr_data_r[0]};
          end
        end
        OFS_NTC: ntc_r <= wr_data_r;
        OFS_MEAS: meas_r <= wr_data_r;
        default: mode_r <= mode_r;
      endcase
    end
  end

  always_comb begin
    case (rd_addr_r)
      OFS_MODE: rd_mux = mode_r;
      OFS_CHG: rd_mux = chg_r;
      OFS_PROT: rd_mux = prot_r;
      OFS_TGA: rd_mux = tga_r;
      OFS_NTC: rd_mux = ntc_r;
      OFS_MEAS: rd_mux = meas_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
      rd_ack_tgl_r <= 1'b0;
    end else if (clk_en && (rd_s_r ^ rd_d_r)) begin
      rd_data_r <= rd_mux;
      rd_ack_tgl_r <= ~rd_ack_tgl_r;
    end
  end

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_mode_r <= MODE_IDLE;
    end else if (clk_en) begin
      if (!act_s_r) begin
        op_mode_r <= MODE_IDLE;
      end else if (mode_r[B_MODE_SRC]) begin
        op_mode_r <= MODE_SOURCE;
      end else begin
        op_mode_r <= MODE_CHARGE;
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  function automatic logic [31:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'h0: wd_limit = 32'(WD_SHORT_TICKS);
      2'h1: wd_limit = 32'(WD_MID_TICKS);
      default: wd_limit = 32'(WD_LONG_TICKS);
    endcase
  endfunction : wd_limit

  function automatic logic [31:0] chg_limit(input logic [1:0] sel);
    case (sel)
      2'h1: chg_limit = 32'(CHG_SHORT_TICKS);
      2'h2: chg_limit = 32'(CHG_MID_TICKS);
      default: chg_limit = 32'(CHG_LONG_TICKS);
    endcase
  endfunction : chg_limit

  logic [31:0] pre_cnt_r, wd_cnt_r, ct_cnt_r, term_cnt_r, bleed_cnt_r;
  logic tick_r, wd_stop_r, ct_stop_r, term_r, bleed_r;
  logic wd_expire, ct_expire;

  // expiry in the same cycle as a restart still sets the stop
  assign wd_expire = tick_r && !wd_stop_r && prot_r[6:5] != WD_OFF &&
    wd_cnt_r >= wd_limit(prot_r[6:5]) - 32'h0000_0001;
  assign ct_expire = tick_r && !ct_stop_r && tga_r[7:6] != CHG_TMO_OFF &&
    op_mode_r == MODE_CHARGE && ct_cnt_r >= chg_limit(tga_r[7:6]) - 32'h0000_0001;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      tick_r <= (pre_cnt_r == 32'(TICK_LEN - 1));
      pre_cnt_r <= (pre_cnt_r == 32'(TICK_LEN - 1)) ? 32'h0000_0000 : pre_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_r <= 32'h0000_0000;
      wd_stop_r <= 1'b0;
    end else if (clk_en) begin
      if (kick) begin
        wd_cnt_r <= 32'h0000_0000;
        wd_stop_r <= wd_expire;
      end else if (prot_r[6:5] == WD_OFF) begin
        wd_cnt_r <= 32'h0000_0000;
      end else if (tick_r && !wd_stop_r) begin
        if (wd_cnt_r >= wd_limit(prot_r[6:5]) - 32'h0000_0001) begin
          wd_stop_r <= 1'b1;
        end else begin
          wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ct_cnt_r <= 32'h0000_0000;
      ct_stop_r <= 1'b0;
    end else if (clk_en) begin
      if (tmr_restart) begin
        ct_cnt_r <= 32'h0000_0000;
        ct_stop_r <= ct_expire;
      end else if (tga_r[7:6] == CHG_TMO_OFF || op_mode_r != MODE_CHARGE) begin
        ct_cnt_r <= 32'h0000_0000;
      end else if (tick_r && !ct_stop_r) begin
        if (ct_cnt_r >= chg_limit(tga_r[7:6]) - 32'h0000_0001) begin
          ct_stop_r <= 1'b1;
        end else begin
          ct_cnt_r <= ct_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_cnt_r <= 32'h0000_0000;
      term_r <= 1'b0;
    end else if (clk_en) begin
      if (op_mode_r != MODE_CHARGE || !batt_at_voltage || !charge_current_low) begin
        term_cnt_r <= 32'h0000_0000;
        term_r <= term_r && op_mode_r == MODE_CHARGE;
      end else if (tick_r) begin
        if (term_cnt_r >= 32'(TERM_TICKS - 1)) begin
          term_r <= term_r | chg_r[B_AUTOTERM];
        end else begin
          term_cnt_r <= term_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bleed_cnt_r <= 32'h0000_0000;
      bleed_r <= 1'b0;
    end else if (clk_en) begin
      if (bleed_go) begin
        bleed_cnt_r <= 32'h0000_0000;
        bleed_r <= 1'b1;
      end else if (bleed_r && tick_r) begin
        if (bleed_cnt_r >= 32'(BLEED_TICKS - 1)) begin
          bleed_r <= 1'b0;
        end else begin
          bleed_cnt_r <= bleed_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------
  // pins and status outputs
  // ----------------------------------------
  logic halt_r, ls1_oe_r, ls2_oe_r, hot_r, cold_r;
  logic [1:0] hot_lim_r, cold_lim_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
      ls1_oe_r <= 1'b0;
      ls2_oe_r <= 1'b0;
      hot_lim_r <= RST_NTC[7:6];
      cold_lim_r <= RST_NTC[5:4];
    end else if (clk_en) begin
      halt_r <= wd_stop_r | ct_stop_r | term_r;
      ls1_oe_r <= ~tga_r[B_LS1];
      ls2_oe_r <= ~mode_r[B_SPREAD] & ~tga_r[B_LS2];
      if (op_mode_r == MODE_SOURCE) begin
        hot_lim_r <= ntc_r[3:2];
        cold_lim_r <= ntc_r[1:0];
      end else begin
        hot_lim_r <= ntc_r[7:6];
        cold_lim_r <= ntc_r[5:4];
      end
    end
  end

  assign op_mode = op_mode_r;
  assign switch_halt = halt_r;
  assign charge_terminated = term_r;
  assign bus_bleed_active = bleed_r;
  assign freq_spread_enable = mode_r[B_SPREAD];
  assign batt_target_source_sel = chg_r[B_TARGET];
  assign charge_current_basis_sel = chg_r[B_BASIS];
  assign precharge_threshold_sel = chg_r[B_PRETH];
  assign precharge_enable = chg_r[B_PREEN];
  assign termination_current_level = chg_r[3:1];
  assign source_out_target_sel = prot_r[B_SRCFB];
  assign source_out_overcurrent_enable = prot_r[B_OCP];
  assign batt_undervolt_threshold_sel = prot_r[B_UVSEL];
  assign inductor_current_limit_sel = prot_r[B_ILIM];
  assign active_hot_limit = hot_lim_r;
  assign active_cold_limit = cold_lim_r;
  assign conversion_start = meas_r[B_ADSTART];
  assign bus_voltage_channel_enable = meas_r[6];
  assign bus_current_channel_enable = meas_r[5];
  assign batt_voltage_channel_enable = meas_r[4];
  assign load_switch1_pin_o = sda_o_r;
  assign load_switch1_pin_oe = ls1_oe_r;
  assign gate2_spread_pin_o = sda_o_r;
  assign gate2_spread_pin_oe = ls2_oe_r;

endmodule : charger_control_register_bank

// >>> testbench/bank_props.sv
`timescale 1ns/10ps
module bank_props
  import charger_regs_pkg::*;
#(parameter int unsigned TICK_LEN = 2) (
  // clock, reset, stimulus
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic converter_active,
  // watched outputs
  input wire logic [1:0] op_mode,
  input wire logic switch_halt,
  input wire logic charge_terminated,
  input wire logic bus_bleed_active,
  input wire logic freq_spread_enable,
  input wire logic batt_target_source_sel,
  input wire logic source_out_target_sel,
  input wire logic gate2_spread_pin_oe,
  input wire logic sda_o,
  input wire logic load_switch1_pin_o,
  input wire logic gate2_spread_pin_o
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int unsigned bleed_cnt_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bleed_cnt_r <= 0;
    else bleed_cnt_r <= bus_bleed_active ? bleed_cnt_r + 1 : 0;
  end
  sequence s_quiet4;
    (clk_en && !converter_active)[*4];
  endsequence
  sequence s_busy4;
    (clk_en && converter_active)[*4];
  endsequence
  sequence s_run3;
    (op_mode != MODE_IDLE)[*3];
  endsequence
  AST_IDLE_MODE: assert property (s_quiet4 |-> op_mode == MODE_IDLE)
    else $error("mode not idle");
  AST_RUN_MODE: assert property (s_busy4 |-> op_mode != MODE_IDLE)
    else $error("mode idle while running");
  AST_TARGET_LOCK: assert property (s_run3 |-> $stable(batt_target_source_sel))
    else $error("target bit changed outside idle");
  AST_SRC_LOCK: assert property (s_run3 |-> $stable(source_out_target_sel))
    else $error("source bit changed outside idle");
  AST_SPREAD_PIN: assert property (freq_spread_enable && clk_en |=> !gate2_spread_pin_oe)
    else $error("gate2 pin driven while spreading");
  AST_PINS_LOW: assert property (!(sda_o || load_switch1_pin_o || gate2_spread_pin_o))
    else $error("open-drain output high");
  AST_TERM_HALT: assert property (charge_terminated && $past(charge_terminated) |-> switch_halt)
    else $error("terminated without halt");
  AST_TERM_CHG: assert property ($rose(charge_terminated) |-> $past(op_mode) == MODE_CHARGE)
    else $error("termination outside charge");
  AST_BLEED_MAX: assert property (bleed_cnt_r <= (BLEED_TICKS + 1) * TICK_LEN + 4)
    else $error("bleed too long");
  AST_BLEED_MIN: assert property ($fell(bus_bleed_active) |-> bleed_cnt_r >= (BLEED_TICKS - 1) * TICK_LEN)
    else $error("bleed too short");
endmodule : bank_props

// >>> testbench/bus_host.sv
`timescale 1ns/10ps
module bus_host #(parameter logic [6:0] DEV = 7'h2A) (
  // serial pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic nak_r;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ---------
  // bus cycles
  // ---------
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    #300 scl = 1'b1;
    s = sda;
    #600 scl = 1'b0;
    #300;
  endtask : clk_bit
  task automatic start();
    sda_low = 1'b0;
    #300 scl = 1'b1;
    #300 sda_low = 1'b1;
    #300 scl = 1'b0;
    #300;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #300 scl = 1'b1;
    #300 sda_low = 1'b0;
    #600;
  endtask : stop
  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, nak_r);
  endtask : tx
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({DEV, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    tx({DEV, 1'b0});
    tx(a);
    start();
    tx({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(1'b1, nak_r);
    stop();
  endtask : rd
endmodule : bus_host

// >>> testbench/tb_charger_control_register_bank.sv
`timescale 1ns/10ps
module tb_charger_control_register_bank
  import charger_regs_pkg::*;
;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, conv = 1'b0, at_v = 1'b0, low_i = 1'b0;
  logic en = 1'b1;
  logic [11:0] cfg;
  logic scl, host_low, sda_oe, halt, term, bleed, tgt, pre_en, ls1_oe, g2_oe;
  logic [1:0] op_mode, hot;
  logic [2:0] tl3;
  wire sda = !(host_low || sda_oe);
  int n_fail = 0, total_checks = 0, n;
  logic [7:0] exp_rst [6] = '{8'h20, 8'h19, 8'h60, 8'h31, 8'h55, 8'h7C};
  always #25 sys_clk = ~sys_clk;
  initial #3 forever #6 link_clk = ~link_clk;
  charger_control_register_bank #(.TICK_LEN(2), .DEV_ADDR(7'h2A)) i_charger_control_register_bank (
    .sys_clk, .rst_n, .clk_en(en), .link_clk, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe,
    .converter_active(conv), .batt_at_voltage(at_v), .charge_current_low(low_i),
    .op_mode, .switch_halt(halt), .charge_terminated(term), .bus_bleed_active(bleed),
    .freq_spread_enable(), .batt_target_source_sel(tgt), .charge_current_basis_sel(cfg[11]),
    .precharge_threshold_sel(cfg[10]), .precharge_enable(pre_en), .termination_current_level(tl3),
    .source_out_target_sel(cfg[9]), .source_out_overcurrent_enable(cfg[8]),
    .batt_undervolt_threshold_sel(cfg[7]), .inductor_current_limit_sel(cfg[6]),
    .active_hot_limit(hot), .active_cold_limit(cfg[5:4]), .conversion_start(cfg[3]),
    .bus_voltage_channel_enable(cfg[2]), .bus_current_channel_enable(cfg[1]),
    .batt_voltage_channel_enable(cfg[0]), .load_switch1_pin_o(), .load_switch1_pin_oe(ls1_oe),
    .gate2_spread_pin_o(), .gate2_spread_pin_oe(g2_oe)
  );
  bus_host #(.DEV(7'h2A)) i_bus_host (.scl, .sda_low(host_low), .sda);
  // -----
  // tasks
  // -----
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_bus_host.rd(a, d);
    check(d, e);
  endtask : rdchk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask : cyc
  task automatic wait_hi(ref logic s, input int k);
    for (int i = 0; i < k && s !== 1'b1; i++) cyc(1);
    check(s, 1'b1);
    if (s !== 1'b1) report_and_stop();
  endtask : wait_hi
  initial begin
    #4_000_000 check(1'b0, 1'b1);
    report_and_stop();
  end
  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(4);
    for (int i = 0; i < 6; i++) rdchk(8'h0B + 8'(i), exp_rst[i]);
    rdchk(8'h11, 8'h00);
    check({pre_en, tl3, hot, ls1_oe, g2_oe}, 8'hC4);
    check(cfg, 12'h017);
    i_bus_host.start();
    i_bus_host.tx(8'h56);
    check(i_bus_host.nak_r, 1'b1);
    i_bus_host.stop();
    $display("test reset done");
    i_bus_host.wr(8'h0C, 8'hEE);
    cyc(6);
    check({tgt, pre_en, tl3}, 5'b10111);
    rdchk(8'h0C, 8'hEE);
    i_bus_host.wr(8'h0E, 8'h01);
    cyc(6);
    check({ls1_oe, g2_oe}, 2'b11);
    i_bus_host.wr(8'h0B, 8'h22);
    cyc(6);
    check({ls1_oe, g2_oe}, 2'b10);
    i_bus_host.wr(8'h0E, 8'h04);
    rdchk(8'h0C, 8'h19);
    rdchk(8'h0E, 8'h31);
    $display("test idle writes done");
    conv = 1'b1;
    cyc(6);
    check(op_mode, MODE_CHARGE);
    i_bus_host.wr(8'h0C, 8'hD9);
    rdchk(8'h0C, 8'h59);
    i_bus_host.wr(8'h0D, 8'hE0);
    rdchk(8'h0D, 8'h60);
    i_bus_host.wr(8'h0B, 8'hA0);
    rdchk(8'h0B, 8'h20);
    i_bus_host.wr(8'h0E, 8'h35);
    rdchk(8'h0C, 8'h59);
    rdchk(8'h0E, 8'h31);
    at_v = 1'b1;
    low_i = 1'b1;
    cyc(9900);
    check(term, 1'b0);
    wait_hi(term, 200);
    cyc(1);
    check(halt, 1'b1);
    conv = 1'b0;
    at_v = 1'b0;
    cyc(6);
    i_bus_host.wr(8'h0B, 8'hA2);
    i_bus_host.wr(8'h0F, 8'h9C);
    i_bus_host.wr(8'h0D, 8'hEE);
    i_bus_host.wr(8'h10, 8'h80);
    en = 1'b0;
    conv = 1'b1;
    cyc(8);
    check(op_mode, MODE_IDLE);
    en = 1'b1;
    cyc(8);
    check({op_mode, hot}, {MODE_SOURCE, 2'b11});
    check(cfg, 12'hBC8);
    conv = 1'b0;
    cyc(8);
    check({op_mode, hot}, {MODE_IDLE, 2'b10});
    $display("test modes done");
    i_bus_host.wr(8'h0D, 8'h10);
    cyc(19800);
    check(halt, 1'b0);
    wait_hi(halt, 400);
    i_bus_host.wr(8'h0D, 8'h70);
    cyc(6);
    check(halt, 1'b0);
    rdchk(8'h0D, 8'h60);
    fork
      i_bus_host.wr(8'h0E, 8'h3B);
      begin
        wait_hi(bleed, 1000);
        for (n = 0; n < 400 && bleed === 1'b1; n++) @(posedge sys_clk);
      end
    join
    check(n >= 196 && n <= 204, 1'b1);
    rdchk(8'h0E, 8'h31);
    $display("test timers done");
    report_and_stop();
  end
endmodule : tb_charger_control_register_bank
bind charger_control_register_bank bank_props #(.TICK_LEN(TICK_LEN)) i_bank_props (
  .sys_clk, .rst_n, .clk_en, .converter_active, .op_mode, .switch_halt, .charge_terminated,
  .bus_bleed_active, .freq_spread_enable, .batt_target_source_sel, .source_out_target_sel,
  .gate2_spread_pin_oe, .sda_o, .load_switch1_pin_o, .gate2_spread_pin_o
);
